// ### logic/pwt_pkg.sv
package pwt_pkg;
    // register map, byte addresses
    localparam logic [7:0] PWT_ADDR_TIMER = 8'h00;
    localparam logic [7:0] PWT_ADDR_CTRL = 8'h04;
    localparam logic [7:0] PWT_ADDR_STATUS = 8'h08;
    // field positions
    localparam int PWT_STAB_LSB = 8;
    localparam int PWT_SAMP_LSB = 0;
    localparam int PWT_CTRL_PWC_EN = 0;
    localparam int PWT_CTRL_WR_EN = 1;
    // reset values
    localparam logic [15:0] PWT_TIMER_RST = 16'h0000;
    localparam logic [1:0] PWT_CTRL_RST = 2'h0;
    // special field codes
    localparam logic [7:0] PWT_LEN_NONE = 8'h00;
    localparam logic [7:0] PWT_SAMP_ALWAYS = 8'hff;
    // pclk and power-control clock periods in ns, and the power-control period rounded up to pclk cycles
    localparam int PWT_PCLK_NS = 20;
    localparam int PWT_TICK_NS = 1000;
    localparam int PWT_TICK_CYCLES = (PWT_TICK_NS + PWT_PCLK_NS - 1) / PWT_PCLK_NS;

    typedef enum logic [1:0] {
        PWT_IDLE,
        PWT_STAB,
        PWT_SAMP
    } pwt_state_t;
endpackage

// ### logic/pwt_tick_gen.sv
`timescale 1ns/1ps
// free-running divider, one-cycle pulse per power-control clock period
module pwt_tick_gen
    import pwt_pkg::*;
#(
    parameter int DIV = PWT_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [15:0] cnt_reg;
    wire last = (cnt_reg == 16'(DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001;
            tick <= last;
        end
    end
endmodule

// ### logic/pwt_top.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - upper byte N nonzero gives stability window of N power-control periods
// - zero stability length: sample window starts at the alarm event
// - lower byte N in 1..254 gives sample window of N periods
// - sample length all ones: sample window always active, even disabled
// - sample length zero: no sample window at all
// - timer register writes ignored unless clock write enable is set
// - sample window starts when stability countdown expires
module pwt_top
    import pwt_pkg::*;
#(
    parameter int TICK_DIV = PWT_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_event,
    output logic stab_window,
    output logic samp_window
);
    ////////////////////////////////////////////////////////////////////
    // input sync
    logic alarm_s1_reg;
    logic alarm_s2_reg;
    logic alarm_s3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_s1_reg <= 1'b0;
            alarm_s2_reg <= 1'b0;
            alarm_s3_reg <= 1'b0;
        end else begin
            alarm_s1_reg <= alarm_event;
            alarm_s2_reg <= alarm_s1_reg;
            alarm_s3_reg <= alarm_s2_reg;
        end
    end
    wire alarm_rise = alarm_s2_reg & ~alarm_s3_reg;

    ////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] timer_reg;
    logic [1:0] ctrl_reg;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_timer = (paddr == PWT_ADDR_TIMER);
    wire hit_ctrl = (paddr == PWT_ADDR_CTRL);
    wire hit_status = (paddr == PWT_ADDR_STATUS);
    wire mapped = hit_timer | hit_ctrl | hit_status;
    wire wr_enable = ctrl_reg[PWT_CTRL_WR_EN];
    wire pwc_en = ctrl_reg[PWT_CTRL_PWC_EN];
    wire timer_wr = wr & hit_timer & wr_enable;
    wire [7:0] stab_len = timer_reg[PWT_STAB_LSB +: 8];
    wire [7:0] samp_len = timer_reg[PWT_SAMP_LSB +: 8];

    wire ctrl_wr = wr & hit_ctrl;

    ////////////////////////////////////////////////////////////////////
    // register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= PWT_TIMER_RST;
        end else if (timer_wr) begin
            timer_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= PWT_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // window engine
    logic tick;
    pwt_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    pwt_state_t state_reg;
    pwt_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    wire samp_always = (samp_len == PWT_SAMP_ALWAYS);
    wire samp_none = (samp_len == PWT_LEN_NONE);
    wire stab_none = (stab_len == PWT_LEN_NONE);
    wire samp_counted = ~samp_none & ~samp_always;
    wire alarm_take = alarm_rise & pwc_en;
    wire stab_load = alarm_take & ~stab_none;
    wire samp_load = alarm_take & stab_none & samp_counted;
    wire cnt_last = (cnt_reg == 8'h01);
    wire period_done = tick & cnt_last;
    wire [7:0] cnt_dec = cnt_reg - 8'h01;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            PWT_IDLE: begin
                if (stab_load) begin
                    state_next = PWT_STAB;
                    cnt_next = stab_len;
                end else if (samp_load) begin
                    state_next = PWT_SAMP;
                    cnt_next = samp_len;
                end
            end
            PWT_STAB: begin
                if (period_done && samp_counted) begin
                    state_next = PWT_SAMP;
                    cnt_next = samp_len;
                end else if (period_done) begin
                    state_next = PWT_IDLE;
                    cnt_next = 8'h00;
                end else if (tick) begin
                    cnt_next = cnt_dec;
                end
            end
            PWT_SAMP: begin
                if (period_done) begin
                    state_next = PWT_IDLE;
                    cnt_next = 8'h00;
                end else if (tick) begin
                    cnt_next = cnt_dec;
                end
            end
            default: begin
                state_next = PWT_IDLE;
                cnt_next = 8'h00;
            end
        endcase
        if (!pwc_en) begin
            state_next = PWT_IDLE;
            cnt_next = 8'h00;
        end
    end

    wire stab_next = (state_next == PWT_STAB);
    wire samp_next_w = (state_next == PWT_SAMP) | samp_always;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PWT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_window <= 1'b0;
        end else begin
            stab_window <= stab_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_window <= 1'b0;
        end else begin
            samp_window <= samp_next_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read path
    wire apb_setup = psel & ~penable;
    wire rd_setup = apb_setup & ~pwrite;
    wire err_next = apb_setup & ~mapped;
    wire [31:0] timer_word = {16'h0000, timer_reg};
    wire [31:0] ctrl_word = {30'h0, ctrl_reg};
    wire [31:0] status_word = {22'h0, cnt_reg, samp_window, stab_window};
    wire [31:0] rd_mux = hit_timer ? timer_word :
                         hit_ctrl ? ctrl_word :
                         hit_status ? status_word : 32'h00000000;
    wire [31:0] rd_next = rd_setup ? rd_mux : 32'h00000000;

    ////////////////////////////////////////////////////////////////////
    // apb response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= err_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= rd_next;
        end
    end
endmodule

// ### verification/pwt_asserts.sv
`timescale 1ns/1ps
module pwt_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_event,
    input wire logic stab_window,
    input wire logic samp_window
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rdy_setup: assert property (psel && !penable |=> pready) else $error("late");
    a_rdy_pulse: assert property (pready |=> !pready) else $error("long");
    a_rd_idle: assert property (!pready |-> prdata == 32'h0) else $error("rd");
    a_err_ready: assert property (pslverr |-> pready) else $error("err");
    a_err_map: assert property (pready |->
        pslverr == (paddr > 8'h08 || paddr[1:0] != 2'h0)) else $error("map");
    a_timer_width: assert property (pready && !pwrite && paddr == 8'h00 |->
        prdata[31:16] == 16'h0) else $error("wide");
    a_stab_cause: assert property ($rose(stab_window) |-> $past(alarm_event, 3))
        else $error("stab");
    a_samp_cause: assert property ($rose(samp_window) |-> $fell(stab_window) ||
        $past(alarm_event, 3) || $past(pready) || $past(pready, 2)) else $error("samp");
    c_stab: cover property ($rose(stab_window));
    c_chain: cover property ($fell(stab_window) && samp_window);
    c_err: cover property (pslverr);
endmodule
////////////////////////////////////////////////////////////////
bind pwt_top pwt_asserts u_chk (.*);

// ### verification/pwt_partner.sv
`timescale 1ns/1ps
module pwt_partner (
    input wire logic pclk,
    input wire logic fire,
    input wire logic stab_window,
    input wire logic samp_window,
    output logic alarm_event = 1'h0,
    output logic [15:0] stab_len,
    output logic [15:0] samp_len
);
    // alarm source and window length meter
    always @(posedge pclk) begin
        alarm_event <= fire;
        stab_len <= (fire && !alarm_event) ? 16'h0 : stab_len + 16'(stab_window);
        samp_len <= (fire && !alarm_event) ? 16'h0 : samp_len + 16'(samp_window);
    end
endmodule

// ### verification/pwt_top_tb.sv
`timescale 1ns/1ps
module pwt_top_tb
    import pwt_pkg::*;
;
    localparam int D = 4;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fire = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, alarm_event, stab_window, samp_window, er;
    logic [15:0] stab_len, samp_len;
    int errors = 0, compares = 0;
    pwt_top #(.TICK_DIV(D)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .alarm_event, .stab_window, .samp_window);
    pwt_partner u_far (.pclk, .fire, .alarm_event, .stab_window, .samp_window, .stab_len,
        .samp_len);
    initial begin
        forever #10 pclk = ~pclk;
    end
    task finish_test;
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, lo, hi);
        compares++;
        if ((g >= lo && g <= hi) !== 1'h1) begin
            errors++;
            $display("MISMATCH %0t %h %h", $time, g, lo);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        logic got;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 9);
        got = pready;
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        if (got !== 1'h1) begin
            errors++;
            finish_test;
        end
    endtask
    task t_regs;
        apb(1'h0, PWT_ADDR_TIMER, 32'h0);
        chk(rd, PWT_TIMER_RST, PWT_TIMER_RST);
        apb(1'h0, PWT_ADDR_CTRL, 32'h0);
        chk(rd, PWT_CTRL_RST, PWT_CTRL_RST);
        apb(1'h1, PWT_ADDR_TIMER, 32'h0305);
        apb(1'h0, PWT_ADDR_TIMER, 32'h0);
        chk(rd, 32'h0, 32'h0);
        apb(1'h0, 8'h0c, 32'h0);
        chk(er, 1'h1, 1'h1);
        apb(1'h1, PWT_ADDR_CTRL, 32'h3);
        apb(1'h1, PWT_ADDR_TIMER, 32'h0305);
        apb(1'h0, PWT_ADDR_TIMER, 32'h0);
        chk(rd, 32'h0305, 32'h0305);
        apb(1'h0, PWT_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0, 32'h0);
    endtask
    task t_win(input logic [7:0] s, m, es, em);
        int i;
        apb(1'h1, PWT_ADDR_TIMER, {16'h0, s, m});
        fire <= 1'h1;
        repeat (6) @(posedge pclk);
        fire <= 1'h0;
        for (i = 0; (stab_window | samp_window) !== 1'h0 && i < 2500; i++) @(negedge pclk);
        @(posedge pclk);
        if ((stab_window | samp_window) !== 1'h0) begin
            errors++;
            finish_test;
        end
        chk(stab_len, es ? (es - 1) * D + 1 : 0, es * D);
        chk(samp_len, em ? (em - 1) * D + 1 : 0, em * D);
    endtask
    task t_always;
        apb(1'h1, PWT_ADDR_TIMER, {24'h0, PWT_SAMP_ALWAYS});
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(samp_window, 1'h1, 1'h1);
        @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs;
        t_win(8'h03, 8'h02, 8'h03, 8'h02);
        t_win(8'h00, 8'h02, 8'h00, 8'h02);
        t_win(8'h02, 8'h00, 8'h02, 8'h00);
        t_win(8'hff, 8'hfe, 8'hff, 8'hfe);
        apb(1'h1, PWT_ADDR_CTRL, 32'h2);
        t_win(8'h03, 8'h02, 8'h00, 8'h00);
        t_always;
        finish_test;
    end
endmodule
